// ===== inc/spt_defines.svh
`ifndef SPT_DEFINES_SVH
`define SPT_DEFINES_SVH
// How it works
// RULE_01 - tick is sysclock/64 divided by prescale value
// RULE_02 - two-bit field selects one of four modes
// RULE_03 - up to two configs; single uses A
// RULE_04 - data match or level hit enters run
// RULE_05 - constant mode: own on times, shared off
// RULE_06 - window end: peak above main and upper
// RULE_07 - on end: peak in wake window
// RULE_08 - hold decided peak, switch to run
// RULE_09 - blocking level suppresses data wake-up
// RULE_10 - level valid goes data, else reobserve
// RULE_11 - sync loss reinitialises, recheck level
// RULE_12 - recognition miss initialises both wake machines
// RULE_13 - level ready sticks until reinitialised
// RULE_14 - data ok wakes; data fail reinitialises
// RULE_15 - fallback: no sync in timeout stops
// RULE_16 - fallback: criterion fails, next config or sleep
// RULE_17 - ultrafast: no level hit, next or sleep
// RULE_18 - level check and sync timer start together
// RULE_19 - ultrafast needs data, extra bit, fallback mode
// RULE_20 - ultrafast: three-threshold window decision
// RULE_21 - fallback on period timed by config A
// RULE_22 - fallback modes only with three receive modes
// RULE_23 - mixed: A constant, B fallback
// RULE_24 - permanent search restarts at A until on ends
// RULE_25 - off expiry starts on with A
// ============================================================
// register map
`define SPT_A_CTRL 8'h00
`define SPT_A_PRES 8'h04
`define SPT_A_ONA 8'h08
`define SPT_A_ONB 8'h0c
`define SPT_A_OFF 8'h10
`define SPT_A_THR 8'h14
`define SPT_A_STO 8'h18
`define SPT_A_STAT 8'h1c
// ============================================================
// fields
`define SPT_F_MODE 1:0
`define SPT_F_MULTI 2
`define SPT_F_XLVL 3
`define SPT_F_DATA 4
`define SPT_F_SREC 5
`define SPT_F_RXM 7:6
`define SPT_F_EN 8
`define SPT_F_TH 7:0
`define SPT_F_BL 15:8
`define SPT_F_BH 23:16
`define SPT_RXM_OTHER 2'h3
// ============================================================
// reset values and counts
`define SPT_RST_CTRL 9'h000
`define SPT_RST_PRES 8'h01
`define SPT_RST_ON 16'h0010
`define SPT_RST_OFF 16'h0040
`define SPT_RST_THR 24'hff0080
`define SPT_RST_STO 16'h0008
`define SPT_PRE_LAST 6'h3f
`endif

// ===== inc/spt_pkg.sv
package spt_pkg;
  typedef enum logic [1:0] {
    constant_on_off = 2'h0,
    fast_fallback = 2'h1,
    mixed_polling = 2'h2,
    permanent_search = 2'h3
  } spt_mode_t;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_off = 5'h02,
    st_lvl = 5'h04,
    st_data = 5'h08,
    st_run = 5'h10
  } spt_state_t;
  typedef struct packed {
    logic [8:0] ctrl;
    logic [7:0] pres;
    logic [15:0] on_a;
    logic [15:0] on_b;
    logic [15:0] off_t;
    logic [15:0] sto;
    logic [23:0] thr;
    logic [31:0] pdata;
    logic rdy;
    logic err;
    spt_state_t st;
    logic rx_on;
    logic run;
    logic cfg_b;
    logic [5:0] pre_cnt;
    logic [7:0] ref_cnt;
    logic tick;
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic [15:0] sync_cnt;
    logic [7:0] peak;
    logic [7:0] peak_hold;
    logic lvl_ready;
    logic wake;
    logic wu_init;
  } spt_regs_t;
endpackage : spt_pkg

// ===== rtl/spt_polling_timer.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "spt_defines.svh"
module spt_polling_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rssi_level,
  input wire logic sig_recog_hit,
  input wire logic obs_end,
  input wire logic sync_ok,
  input wire logic sync_lost,
  input wire logic data_ok,
  input wire logic data_fail,
  input wire logic run_exit,
  output logic rx_on,
  output logic cfg_b_sel,
  output logic run_mode,
  output logic wake_pulse,
  output logic wu_init,
  output spt_pkg::spt_state_t fsm_state
);
  import spt_pkg::*;

  localparam spt_regs_t RST = '{
    default: '0,
    ctrl: `SPT_RST_CTRL,
    pres: `SPT_RST_PRES,
    on_a: `SPT_RST_ON,
    on_b: `SPT_RST_ON,
    off_t: `SPT_RST_OFF,
    sto: `SPT_RST_STO,
    thr: `SPT_RST_THR,
    st: st_idle
  };

  spt_regs_t r;
  spt_regs_t n;
  spt_mode_t mode;
  logic acc;
  logic wr;
  logic mode_err;
  logic multi;
  logic xlvl;
  logic datac;
  logic srec;
  logic en;
  logic ffb_a;
  logic ffb_cfg;
  logic ultrafast_fallback;
  logic gate;
  logic pre_wrap;
  logic on_exp;
  logic off_exp;
  logic sync_exp;
  logic win_ok;
  logic coo_hit;
  logic blocked;
  logic lvl_ok;
  logic go_wake;
  logic go_next;
  logic restart_on;
  logic [7:0] th;
  logic [7:0] bl;
  logic [7:0] bh;

  // ============================================================
  // decoders
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `SPT_A_CTRL, `SPT_A_PRES, `SPT_A_ONA, `SPT_A_ONB,
      `SPT_A_OFF, `SPT_A_THR, `SPT_A_STO, `SPT_A_STAT: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  // a programmed count of 0 behaves as 1 tick
  function automatic logic expired(input logic [15:0] c, input logic t);
    expired = t && (c <= 16'h0001);
  endfunction : expired

  function automatic logic in_window(input logic [7:0] p, input logic [7:0] t,
                                     input logic [7:0] lo, input logic [7:0] hi);
    in_window = (p > t) && ((p < lo) || (p > hi));
  endfunction : in_window

  // level gating applies to constant configs and to ultrafast ones only
  function automatic spt_state_t first_state(input logic ffbx);
    first_state = (datac && !(xlvl && (ffbx ? ultrafast_fallback : 1'b1))) ? st_data : st_lvl;
  endfunction : first_state

  // ============================================================
  // next state
  always_comb begin
    n = r;
    n.wake = 1'b0;
    n.wu_init = 1'b0;
    n.tick = 1'b0;
    go_wake = 1'b0;
    go_next = 1'b0;
    restart_on = 1'b0;
    lvl_ok = 1'b0;
    mode = spt_mode_t'(r.ctrl[`SPT_F_MODE]); // RULE_02
    mode_err = 1'b0;
    if (mode != constant_on_off && r.ctrl[`SPT_F_RXM] == `SPT_RXM_OTHER) begin // RULE_22
      mode = constant_on_off;
      mode_err = 1'b1;
    end
    multi = r.ctrl[`SPT_F_MULTI];
    xlvl = r.ctrl[`SPT_F_XLVL];
    datac = r.ctrl[`SPT_F_DATA];
    srec = r.ctrl[`SPT_F_SREC];
    en = r.ctrl[`SPT_F_EN];
    th = r.thr[`SPT_F_TH];
    bl = r.thr[`SPT_F_BL];
    bh = r.thr[`SPT_F_BH];
    ffb_a = (mode == fast_fallback) || (mode == permanent_search);
    ffb_cfg = ffb_a || (mode == mixed_polling && r.cfg_b); // RULE_23
    ultrafast_fallback = datac && xlvl && ffb_a; // RULE_19
    gate = datac && xlvl && (ffb_cfg ? ultrafast_fallback : 1'b1);
    win_ok = in_window(r.peak, th, bl, bh); // RULE_20
    coo_hit = (r.peak > th) && (r.peak > bh); // RULE_06
    blocked = (r.peak >= bl) && (r.peak <= bh);

    // apb slave, one wait state on every access
    acc = psel && penable;
    wr = acc && r.rdy && pwrite;
    n.rdy = acc && !r.rdy;
    n.err = acc && !r.rdy && !reg_hit(paddr);
    if (acc && !r.rdy) begin
      case (paddr)
        `SPT_A_CTRL: n.pdata = {23'h000000, r.ctrl};
        `SPT_A_PRES: n.pdata = {24'h000000, r.pres};
        `SPT_A_ONA: n.pdata = {16'h0000, r.on_a};
        `SPT_A_ONB: n.pdata = {16'h0000, r.on_b};
        `SPT_A_OFF: n.pdata = {16'h0000, r.off_t};
        `SPT_A_THR: n.pdata = {8'h00, r.thr};
        `SPT_A_STO: n.pdata = {16'h0000, r.sto};
        `SPT_A_STAT: n.pdata = {15'h0000, r.st, mode_err, r.lvl_ready, r.run, r.cfg_b, r.peak_hold};
        default: n.pdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `SPT_A_CTRL: n.ctrl = pwdata[8:0];
        `SPT_A_PRES: n.pres = pwdata[7:0];
        `SPT_A_ONA: n.on_a = pwdata[15:0]; // RULE_05
        `SPT_A_ONB: n.on_b = pwdata[15:0];
        `SPT_A_OFF: n.off_t = pwdata[15:0];
        `SPT_A_THR: n.thr = pwdata[23:0];
        `SPT_A_STO: n.sto = pwdata[15:0];
        default: n.pdata = r.pdata;
      endcase
    end

    // ============================================================
    // reference timer: fixed /64 then programmable divide
    pre_wrap = (r.pre_cnt == `SPT_PRE_LAST);
    n.pre_cnt = r.pre_cnt + 6'h01;
    if (pre_wrap) begin
      if (8'(r.ref_cnt + 8'h01) >= r.pres) begin // RULE_01
        n.ref_cnt = 8'h00;
        n.tick = 1'b1;
      end else begin
        n.ref_cnt = r.ref_cnt + 8'h01;
      end
    end

    // ============================================================
    // on-off and sync timers
    on_exp = expired(r.on_cnt, r.tick);
    // the off period only counts once the on period is used up, so an early
    // fallback shutdown keeps the master period fixed
    off_exp = expired(r.off_cnt, r.tick) && (r.on_cnt == 16'h0000); // RULE_21
    sync_exp = ffb_cfg && !sync_ok && expired(r.sync_cnt, r.tick);
    // on timer keeps running while asleep early; receiver shutdown does not stop it
    if (r.tick && (r.rx_on || r.st == st_off) && r.on_cnt != 16'h0000) begin
      n.on_cnt = r.on_cnt - 16'h0001; // RULE_21
    end
    if (r.tick && r.st == st_off && r.on_cnt == 16'h0000 && r.off_cnt != 16'h0000) begin
      n.off_cnt = r.off_cnt - 16'h0001;
    end
    // timeout only runs while no bit-stream lock is held
    if (r.tick && r.rx_on && !sync_ok && r.sync_cnt != 16'h0000) begin
      n.sync_cnt = r.sync_cnt - 16'h0001;
    end
    if (r.rx_on && rssi_level > r.peak) begin
      n.peak = rssi_level;
    end

    // ============================================================
    // control fsm
    case (r.st)
      st_idle: begin
        restart_on = en;
      end
      st_off: begin
        restart_on = off_exp; // RULE_25
      end
      st_run: begin
        restart_on = run_exit;
      end
      st_lvl: begin
        if (on_exp) begin
          if (!datac && !ffb_cfg && (srec ? sig_recog_hit : win_ok)) begin // RULE_07
            go_wake = 1'b1;
          end else begin
            go_next = 1'b1;
          end
        end else if (sync_exp) begin
          go_next = 1'b1; // RULE_15
        end else if (obs_end) begin
          if (!datac) begin
            go_wake = srec ? sig_recog_hit : (ffb_cfg ? win_ok : coo_hit); // RULE_04 RULE_06
          end else begin
            lvl_ok = srec ? sig_recog_hit : win_ok; // RULE_20
            if (lvl_ok) begin
              n.lvl_ready = 1'b1; // RULE_13
              n.st = st_data; // RULE_10
            end else if (ffb_cfg) begin
              go_next = 1'b1; // RULE_17
            end else begin
              // new observation period; both wake machines restart
              n.wu_init = 1'b1; // RULE_10 RULE_12
              n.lvl_ready = 1'b0;
            end
          end
        end
      end
      st_data: begin
        if (on_exp) begin
          go_next = 1'b1;
        end else if (sync_exp) begin
          go_next = 1'b1; // RULE_15
        end else if (data_ok && !(gate && blocked)) begin
          go_wake = 1'b1; // RULE_04 RULE_09 RULE_14
        end else if (data_fail) begin
          if (ffb_cfg) begin
            go_next = 1'b1; // RULE_16
          end else begin
            n.wu_init = 1'b1; // RULE_14
            n.lvl_ready = 1'b0;
            n.st = first_state(ffb_cfg);
          end
        end else if (sync_lost) begin
          n.wu_init = 1'b1; // RULE_11
          n.lvl_ready = 1'b0;
          n.st = first_state(ffb_cfg);
        end
      end
      default: begin
        n.st = st_idle;
      end
    endcase

    if (go_wake) begin
      n.st = st_run;
      n.wake = 1'b1;
      n.peak_hold = r.peak; // RULE_08
    end else if (restart_on) begin
      n.st = first_state(ffb_a); // RULE_25
      n.cfg_b = 1'b0;
      n.on_cnt = r.on_a;
      n.sync_cnt = r.sto; // RULE_18
      n.peak = 8'h00;
      n.wu_init = 1'b1;
      n.lvl_ready = 1'b0;
    end else if (go_next) begin
      n.wu_init = 1'b1;
      n.lvl_ready = 1'b0;
      n.peak = 8'h00;
      n.sync_cnt = r.sto; // RULE_18
      if (!r.cfg_b && multi) begin // RULE_03
        n.cfg_b = 1'b1;
        // fallback keeps one on period across configs
        if (!ffb_a) begin
          n.on_cnt = r.on_b; // RULE_05 RULE_21 RULE_23
        end
        n.st = first_state(ffb_a || mode == mixed_polling);
      end else if (mode == permanent_search && !on_exp) begin
        n.cfg_b = 1'b0; // RULE_24
        n.st = first_state(1'b1);
      end else begin
        n.cfg_b = 1'b0;
        n.st = st_off; // RULE_16 RULE_17
        n.off_cnt = r.off_t; // RULE_25
      end
    end
    if (!en) begin
      n.st = st_idle;
      n.cfg_b = 1'b0;
    end
    n.rx_on = (n.st == st_lvl) || (n.st == st_data);
    n.run = (n.st == st_run);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.pdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign rx_on = r.rx_on;
  assign cfg_b_sel = r.cfg_b;
  assign run_mode = r.run;
  assign wake_pulse = r.wake;
  assign wu_init = r.wu_init;
  assign fsm_state = r.st;

  // ============================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tick_from_prescale_a: assert property (r.tick |-> $past(r.pre_cnt) == `SPT_PRE_LAST) // RULE_01
    else $error("tick not aligned to the /64 prescaler");
  mode_fallback_a: assert property (mode != spt_mode_t'(r.ctrl[`SPT_F_MODE]) |->
    r.ctrl[`SPT_F_RXM] == `SPT_RXM_OTHER) // RULE_22
    else $error("mode override without illegal receive mode");
  single_cfg_a: assert property ($rose(r.cfg_b) |-> $past(r.ctrl[`SPT_F_MULTI])) // RULE_03
    else $error("config B used in single mode");
  run_entry_a: assert property ($rose(r.run) |-> r.wake && r.peak_hold == $past(r.peak)) // RULE_08
    else $error("run entered without wake or held peak");
  ffb_on_kept_a: assert property ($rose(r.cfg_b) && ffb_a |-> r.on_cnt <= $past(r.on_cnt)) // RULE_21
    else $error("on timer reloaded on config change in fallback");
  off_to_on_a: assert property (r.st == st_off && off_exp && en |=> r.rx_on && !r.cfg_b ##1 r.rx_on) // RULE_25
    else $error("off expiry did not start config A");
  ready_sticky_a: assert property ($fell(r.lvl_ready) |-> r.wu_init || !r.ctrl[`SPT_F_EN]) // RULE_13
    else $error("level ready dropped without init");
  sync_loss_a: assert property (r.st == st_data && sync_lost && !data_ok && !data_fail && !on_exp
    && !sync_exp && en |=> r.wu_init && !r.lvl_ready) // RULE_11
    else $error("sync loss did not reinitialise");
  sync_timeout_a: assert property (r.st == st_lvl && sync_exp && !on_exp && en |=> r.wu_init) // RULE_15
    else $error("sync timeout ignored");

  // off period must not eat into a running on period
  off_after_on_a: assert property (r.st == st_off && r.on_cnt != 16'h0000 |=> r.off_cnt == $past(r.off_cnt)) // RULE_21
    else $error("off timer ran inside the on period");

  // wake strobe is a single cycle
  wake_single_a: assert property (r.wake |=> !r.wake) // RULE_08
    else $error("wake pulse longer than one cycle");

  // constant configs load their own on time when moving to config B
  cfg_b_on_a: assert property ($rose(r.cfg_b) && !ffb_a |-> r.on_cnt == $past(r.on_b)) // RULE_05
    else $error("config B on time not loaded");

  // blocking level vetoes a data match when level gating is active
  block_veto_a: assert property (r.st == st_data && data_ok && gate && blocked && !on_exp && !sync_exp
    && en |=> !r.run) // RULE_09
    else $error("data wake-up despite blocking level");

  // a valid level hands over to the data search and marks ready
  lvl_to_data_a: assert property (r.st == st_lvl && datac && obs_end && !on_exp && !sync_exp && en
    && (srec ? sig_recog_hit : win_ok) |=> r.st == st_data && r.lvl_ready) // RULE_10
    else $error("valid level did not start data search");

  // constant mode window decision on peak above main and upper
  coo_window_a: assert property (r.st == st_lvl && !datac && !srec && !ffb_cfg && obs_end && !on_exp
    && !sync_exp && coo_hit && en |=> r.run) // RULE_06
    else $error("window hit did not wake");

endmodule : spt_polling_timer

// ===== testbench/spt_tx_model.sv
`timescale 1ns/10ps
module spt_tx_model #(parameter int OBS_CYC = 40) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_on,
  input wire logic [7:0] tx_level,
  input wire logic tx_sync,
  output logic [7:0] rssi_level,
  output logic obs_end,
  output logic sync_ok
);
  int cnt;
  // an idle receiver only sees the noise floor, never the last level heard
  assign rssi_level = rx_on ? tx_level : 8'h00;
  assign sync_ok = rx_on & tx_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      obs_end <= 1'b0;
    end else begin
      cnt <= (rx_on && cnt < OBS_CYC - 1) ? cnt + 1 : 0;
      obs_end <= rx_on && cnt == OBS_CYC - 1;
    end
  end
endmodule : spt_tx_model

// ===== testbench/self_polling_wakeup_timer_tb.sv
`timescale 1ns/10ps
module self_polling_wakeup_timer_tb;
  import spt_pkg::*;
  localparam int TICK = 64;
  localparam int ON = 4;
  localparam int OFF = 4;
  localparam int STO = 2;
  localparam logic [7:0] MAIN = 8'h20;
  localparam logic [7:0] LOW = 8'h60;
  localparam logic [7:0] UPP = 8'hc0;
  localparam logic [31:0] RST [9] = '{0, 1, 'h10, 'h10, 'h40, 'hff0080, 8, 'h1000, 0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, obs_end, sync_ok, rx_on, cfg_b_sel, run_mode, wake_pulse;
  logic [7:0] rssi_level;
  logic [7:0] tx_level = 8'h00;
  logic tx_sync = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [2:0] outs;
  spt_state_t fsm_state;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h3931cfd1;
  int cyc = 0;
  assign outs = {run_mode, cfg_b_sel, rx_on};
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc++;
  spt_polling_timer spt_polling_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rssi_level(rssi_level), .sig_recog_hit(1'b0), .obs_end(obs_end), .sync_ok(sync_ok), .sync_lost(1'b0),
    .data_ok(ev[0]), .data_fail(ev[1]), .run_exit(ev[2]), .rx_on(rx_on), .cfg_b_sel(cfg_b_sel),
    .run_mode(run_mode), .wake_pulse(wake_pulse), .wu_init(), .fsm_state(fsm_state));
  spt_tx_model spt_tx_model_inst (.pclk(pclk), .presetn(presetn), .rx_on(rx_on), .tx_level(tx_level),
    .tx_sync(tx_sync), .rssi_level(rssi_level), .obs_end(obs_end), .sync_ok(sync_ok));
  // ============================================================
  // helpers
  function automatic logic exp_win(input logic [7:0] l);
    return l > MAIN && l > UPP;
  endfunction : exp_win
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      close_out();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic [2:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 3'h0;
  endtask : pulse
  // bit 0 receiver on, 1 config b, 2 run mode
  task automatic waitv(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (outs[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(n < lim, 1);
  endtask : waitv
  // ============================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] c;
    logic [7:0] lv;
    logic got, w;
    int n, t0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(fsm_state, st_idle);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, q);
      chk(q, RST[i]);
      chk(last_err, i == 8);
    end
    apb(1'b1, 8'h04, 32'h1, q);
    apb(1'b1, 8'h08, ON, q);
    apb(1'b1, 8'h0c, ON, q);
    apb(1'b1, 8'h10, OFF, q);
    apb(1'b1, 8'h14, {8'h00, UPP, LOW, MAIN}, q);
    apb(1'b1, 8'h18, STO, q);
    for (int m = 0; m < 8; m++) begin
      c = 32'h100 + (m % 4) + (m / 4) * 32'hc0;
      apb(1'b1, 8'h00, c, q);
      apb(1'b0, 8'h00, 0, q);
      chk(q, c);
      apb(1'b0, 8'h1c, 0, q);
      chk(q[11], m > 4);
    end
    apb(1'b1, 8'h00, 32'h0, q);
    for (int i = 0; i < 10; i++) begin
      lv = (i < 2) ? UPP + 8'(i) : 8'($random(seed));
      tx_level <= lv;
      apb(1'b1, 8'h00, 32'h100, q);
      got = 1'b0;
      w = 1'b0;
      repeat (100) begin
        @(posedge pclk);
        got |= run_mode;
        w |= wake_pulse;
      end
      chk(got, exp_win(lv));
      chk(w, exp_win(lv));
      if (got) begin
        apb(1'b0, 8'h1c, 0, q);
        chk(q[9:0], {2'b10, lv});
      end
      apb(1'b1, 8'h00, 32'h0, q);
    end
    // peak between main and lower: only the on-end decision may wake
    tx_level <= 8'h40;
    apb(1'b1, 8'h00, 32'h100, q);
    waitv(2, 1'b1, ON * TICK + 100, n);
    chk(n > (ON - 1) * TICK, 1);
    tx_level <= 8'h80;
    pulse(3'h4);
    waitv(0, 1'b1, 5, n);
    waitv(0, 1'b0, ON * TICK + 100, n);
    chk(run_mode, 0);
    waitv(0, 1'b1, (OFF + 1) * TICK, n);
    chk(n >= (OFF - 1) * TICK, 1);
    chk(cfg_b_sel, 0);
    apb(1'b1, 8'h00, 32'h0, q);
    tx_sync <= 1'b0;
    apb(1'b1, 8'h00, 32'h115, q);
    t0 = cyc;
    waitv(1, 1'b1, (STO + 1) * TICK + 20, n);
    chk(n >= (STO - 1) * TICK, 1);
    tx_sync <= 1'b1;
    pulse(3'h2);
    waitv(0, 1'b0, 4, n);
    waitv(0, 1'b1, (ON + OFF + 1) * TICK, n);
    chk(cyc - t0 >= (ON + OFF - 1) * TICK && cyc - t0 <= (ON + OFF + 1) * TICK, 1);
    chk(cfg_b_sel, 0);
    pulse(3'h1);
    waitv(2, 1'b1, 4, n);
    close_out();
  end
  initial begin
    #500000;
    n_fail++;
    close_out();
  end
endmodule : self_polling_wakeup_timer_tb
